// [hdl/mamr_pkg.sv]
package mamr_pkg;

  // Frame field widths and codes.
  localparam int PRE_BITS = 32;
  localparam int FRAME_BITS = 64;
  localparam logic [1:0] START_CODE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] TA_WRITE = 2'h2;
  localparam logic [4:0] REG_STATUS = 5'h01;
  localparam logic [4:0] REG_PARTNER = 5'h05;

  // Frame bit positions, counted from the first preamble bit.
  localparam int TA_FIRST = 46;
  localparam int DATA_FIRST = 48;
  localparam int IDLE_BIT = 64;

  // Status and partner ability fields.
  localparam int AN_DONE_BIT = 5;
  localparam int LP_100FD_BIT = 8;
  localparam int LP_100HD_BIT = 7;
  localparam int LP_10FD_BIT = 6;
  localparam int LP_10HD_BIT = 5;

  // Link clock timing in ns and in 4 ns clock cycles.
  localparam int CLK_NS = 4;
  localparam int MDC_HIGH_NS = 160;
  localparam int MDC_LOW_NS = 160;
  localparam int MDC_PERIOD_NS = 400;
  localparam int HIGH_CYC = (MDC_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOW_MIN_CYC = (MDC_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int PERIOD_CYC = (MDC_PERIOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOW_CYC = (PERIOD_CYC - HIGH_CYC > LOW_MIN_CYC) ? PERIOD_CYC - HIGH_CYC : LOW_MIN_CYC;
  localparam int HALF_W = 8;

  // Negotiation timeout.
  localparam longint AN_TIMEOUT_S = 5;
  localparam longint AN_TIMEOUT_CYC = AN_TIMEOUT_S * 1000000000 / CLK_NS;

  // Outcome codes.
  localparam logic [2:0] LINK_NONE = 3'h0;
  localparam logic [2:0] LINK_100FD = 3'h1;
  localparam logic [2:0] LINK_100HD = 3'h2;
  localparam logic [2:0] LINK_10FD = 3'h3;
  localparam logic [2:0] LINK_10HD = 3'h4;
  localparam logic [2:0] LINK_FAIL = 3'h7;

endpackage : mamr_pkg

// [hdl/mamr_mdc_gen.sv]
`timescale 1ns/1ps
// Divides the core clock into the management clock. The rise and fall
// pulses mark the cycle in which the clock level changes.
module mamr_mdc_gen #(
  parameter int HIGH_CYC = mamr_pkg::HIGH_CYC,
  parameter int LOW_CYC = mamr_pkg::LOW_CYC
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic run_in,
  output logic mdc_out,
  output logic rise_out,
  output logic fall_out
);

  logic [mamr_pkg::HALF_W-1:0] cnt_q, cnt_d;
  logic mdc_q, mdc_d;
  logic rise_d, fall_d;

  always_comb begin
    cnt_d = cnt_q;
    mdc_d = mdc_q;
    rise_d = 1'b0;
    fall_d = 1'b0;
    if (!run_in) begin
      cnt_d = '0;
      mdc_d = 1'b0;
    end else if (mdc_q && cnt_q == mamr_pkg::HALF_W'(HIGH_CYC - 1)) begin
      cnt_d = '0;
      mdc_d = 1'b0;
      fall_d = 1'b1;
    end else if (!mdc_q && cnt_q == mamr_pkg::HALF_W'(LOW_CYC - 1)) begin
      cnt_d = '0;
      mdc_d = 1'b1;
      rise_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q <= '0;
      mdc_q <= 1'b0;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      mdc_q <= mdc_d;
      rise_out <= rise_d;
      fall_out <= fall_d;
    end
  end

  assign mdc_out = mdc_q;

endmodule : mamr_mdc_gen

// [hdl/mamr_top.sv]
`timescale 1ns/1ps
module mamr_top #(
  parameter logic [4:0] PHY_ADDR = 5'h01,
  parameter longint TIMEOUT_CYC = mamr_pkg::AN_TIMEOUT_CYC
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic start_in,
  input wire logic pin_mode_in,
  input wire logic pin_mdc_in,
  input wire logic pin_mdio_in,
  input wire logic pin_mdio_oe_in,
  input wire logic mdio_in,
  output logic mdc_out,
  output logic mdio_out,
  output logic mdio_oe_out,
  output logic pin_mdio_level_out,
  output logic busy_out,
  output logic done_out,
  output logic [2:0] link_mode_out,
  output logic duplex_select_bit_out
);

  typedef enum logic [5:0] {
    MAMR_IDLE = 6'h01,
    MAMR_STAT = 6'h02,
    MAMR_WAIT = 6'h04,
    MAMR_PART = 6'h08,
    MAMR_DONE = 6'h10,
    MAMR_FAIL = 6'h20
  } mamr_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and clock divider.

  logic mdio_s1_q, mdio_s2_q;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mdio_s1_q <= 1'b1;
      mdio_s2_q <= 1'b1;
    end else begin
      mdio_s1_q <= mdio_in;
      mdio_s2_q <= mdio_s1_q;
    end
  end

  logic run_q, run_d;
  logic mdc_raw, rise_p, fall_p;

  mamr_mdc_gen u_mdc (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .run_in(run_q),
    .mdc_out(mdc_raw),
    .rise_out(rise_p),
    .fall_out(fall_p)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame shifter: one bit per link clock period.

  function automatic logic [63:0] build_read(input logic [4:0] regad);
    build_read = {{mamr_pkg::PRE_BITS{1'b1}}, mamr_pkg::START_CODE, mamr_pkg::OP_READ, PHY_ADDR, regad,
                  2'h0, 16'h0000};
  endfunction : build_read

  logic [63:0] sh_q, sh_d;
  logic [6:0] bit_q, bit_d;
  logic [15:0] rdata_q, rdata_d;
  logic frame_go, frame_end;
  logic [4:0] frame_reg;
  logic drive_q, drive_d;
  logic out_q, out_d;

  // A frame spans 64 bits plus the idle bit; the idle bit is released like the turnaround.
  always_comb begin
    sh_d = sh_q;
    bit_d = bit_q;
    rdata_d = rdata_q;
    run_d = run_q;
    drive_d = drive_q;
    out_d = out_q;
    frame_end = 1'b0;
    if (frame_go && !run_q) begin
      sh_d = build_read(frame_reg);
      bit_d = '0;
      run_d = 1'b1;
      drive_d = 1'b1;
      out_d = 1'b1;
    end else if (run_q && fall_p) begin
      // New bit presented on the falling edge so it is stable around the rise.
      bit_d = bit_q + 7'h01;
      sh_d = {sh_q[62:0], 1'b0};
      out_d = sh_q[62];
      drive_d = (bit_d < 7'(mamr_pkg::TA_FIRST));
      if (bit_q == 7'(mamr_pkg::IDLE_BIT)) begin
        run_d = 1'b0;
        drive_d = 1'b0;
        frame_end = 1'b1;
      end
    end else if (run_q && rise_p && bit_q >= 7'(mamr_pkg::DATA_FIRST) && bit_q < 7'(mamr_pkg::IDLE_BIT)) begin
      rdata_d = {rdata_q[14:0], mdio_s2_q};
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sh_q <= '0;
      bit_q <= '0;
      rdata_q <= '0;
      run_q <= 1'b0;
      drive_q <= 1'b0;
      out_q <= 1'b1;
    end else begin
      sh_q <= sh_d;
      bit_q <= bit_d;
      rdata_q <= rdata_d;
      run_q <= run_d;
      drive_q <= drive_d;
      out_q <= out_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Negotiation sequencer.

  mamr_state_t st_q, st_d;
  logic [39:0] tmo_q, tmo_d;
  logic [2:0] mode_q, mode_d;
  logic dm_q, dm_d;
  logic done_q, done_d;
  logic issued_q, issued_d;

  assign frame_go = (st_q == MAMR_STAT || st_q == MAMR_PART) && !issued_q;
  assign frame_reg = (st_q == MAMR_PART) ? mamr_pkg::REG_PARTNER : mamr_pkg::REG_STATUS;

  always_comb begin
    st_d = st_q;
    tmo_d = tmo_q;
    mode_d = mode_q;
    dm_d = dm_q;
    done_d = done_q;
    issued_d = issued_q;
    if (frame_go) begin
      issued_d = 1'b1;
    end
    if (st_q != MAMR_IDLE && st_q != MAMR_DONE && st_q != MAMR_FAIL) begin
      tmo_d = tmo_q + 40'h1;
    end
    case (st_q)
      MAMR_IDLE: begin
        if (start_in) begin
          st_d = MAMR_STAT;
          tmo_d = '0;
          issued_d = 1'b0;
          done_d = 1'b0;
        end
      end
      MAMR_STAT: begin
        if (frame_end) begin
          issued_d = 1'b0;
          if (rdata_q[mamr_pkg::AN_DONE_BIT]) begin
            st_d = MAMR_PART;
          end else if (tmo_q >= 40'(TIMEOUT_CYC)) begin
            st_d = MAMR_FAIL;
          end else begin
            st_d = MAMR_STAT;
          end
        end
      end
      MAMR_PART: begin
        if (frame_end) begin
          issued_d = 1'b0;
          st_d = MAMR_DONE;
          // Highest common mode wins, mirroring the transceiver's choice.
          if (rdata_q[mamr_pkg::LP_100FD_BIT]) begin
            mode_d = mamr_pkg::LINK_100FD;
            dm_d = 1'b1;
          end else if (rdata_q[mamr_pkg::LP_100HD_BIT]) begin
            mode_d = mamr_pkg::LINK_100HD;
            dm_d = 1'b0;
          end else if (rdata_q[mamr_pkg::LP_10FD_BIT]) begin
            mode_d = mamr_pkg::LINK_10FD;
            dm_d = 1'b1;
          end else if (rdata_q[mamr_pkg::LP_10HD_BIT]) begin
            mode_d = mamr_pkg::LINK_10HD;
            dm_d = 1'b0;
          end else begin
            mode_d = mamr_pkg::LINK_FAIL;
          end
        end
      end
      MAMR_DONE, MAMR_FAIL: begin
        done_d = 1'b1;
        if (st_q == MAMR_FAIL) begin
          mode_d = mamr_pkg::LINK_FAIL;
        end
        st_d = MAMR_IDLE;
      end
      default: st_d = MAMR_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= MAMR_IDLE;
      tmo_q <= '0;
      mode_q <= mamr_pkg::LINK_NONE;
      dm_q <= 1'b0;
      done_q <= 1'b0;
      issued_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmo_q <= tmo_d;
      mode_q <= mode_d;
      dm_q <= dm_d;
      done_q <= done_d;
      issued_q <= issued_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs with software override.

  logic mdc_o_q, mdio_o_q, oe_o_q, lvl_q, busy_q;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mdc_o_q <= 1'b0;
      mdio_o_q <= 1'b1;
      oe_o_q <= 1'b0;
      lvl_q <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      // Override only while no frame is being shifted (run_q low), so no frame is torn apart.
      if (pin_mode_in && !run_q) begin
        mdc_o_q <= pin_mdc_in;
        mdio_o_q <= pin_mdio_in;
        oe_o_q <= pin_mdio_oe_in;
      end else begin
        mdc_o_q <= mdc_raw;
        mdio_o_q <= out_q;
        oe_o_q <= drive_q;
      end
      lvl_q <= mdio_s2_q;
      busy_q <= (st_q != MAMR_IDLE);
    end
  end

  assign mdc_out = mdc_o_q;
  assign mdio_out = mdio_o_q;
  assign mdio_oe_out = oe_o_q;
  assign pin_mdio_level_out = lvl_q;
  assign busy_out = busy_q;
  assign done_out = done_q;
  assign link_mode_out = mode_q;
  assign duplex_select_bit_out = dm_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  logic [7:0] hi_cnt_q;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hi_cnt_q <= '0;
    end else begin
      hi_cnt_q <= mdc_raw ? hi_cnt_q + 8'h01 : 8'h00;
    end
  end

  property p_high_width;
    @(posedge clk_in) disable iff (!resetn_in) $fell(mdc_raw) |-> hi_cnt_q >= 8'(mamr_pkg::HIGH_CYC);
  endproperty
  a_high_width: assert property (p_high_width) else $error("clock high too short");

  property p_pre_ones;
    @(posedge clk_in) disable iff (!resetn_in) run_q && bit_q < 7'(mamr_pkg::PRE_BITS) |-> out_q && drive_q;
  endproperty
  a_pre_ones: assert property (p_pre_ones) else $error("preamble not driven high");

  property p_release;
    @(posedge clk_in) disable iff (!resetn_in) run_q && bit_q >= 7'(mamr_pkg::TA_FIRST) |-> !drive_q;
  endproperty
  a_release: assert property (p_release) else $error("line driven after turnaround");

  // Start pattern then read code: frame bits 32 to 35 must be 0, 1, 1, 0.
  property p_start_code;
    @(posedge clk_in) disable iff (!resetn_in)
      run_q && bit_q >= 7'(mamr_pkg::PRE_BITS) && bit_q < 7'h24 |-> out_q == (bit_q == 7'h21 || bit_q == 7'h22);
  endproperty
  a_start_code: assert property (p_start_code) else $error("start or read code wrong");

  property p_change_low;
    @(posedge clk_in) disable iff (!resetn_in) run_q && $changed(out_q) |-> !mdc_raw;
  endproperty
  a_change_low: assert property (p_change_low) else $error("data changed while clock high");

  property p_fail_keeps;
    @(posedge clk_in) disable iff (!resetn_in) st_q == MAMR_FAIL |=> $stable(dm_q);
  endproperty
  a_fail_keeps: assert property (p_fail_keeps) else $error("duplex changed on failure");

  c_done: cover property (@(posedge clk_in) disable iff (!resetn_in) st_q == MAMR_DONE);
  c_fail: cover property (@(posedge clk_in) disable iff (!resetn_in) st_q == MAMR_FAIL);
  c_full: cover property (@(posedge clk_in) disable iff (!resetn_in) $rose(dm_q));

endmodule : mamr_top

// [sim/mamr_phy_model.sv]
`timescale 1ns/1ps
// Behavioural transceiver on the management link. It answers read frames and
// counts every timing or drive fault that it sees on the wire.
module mamr_phy_model (
  input wire logic mdc_in,
  input wire logic mdio_in,
  input wire logic mst_oe_in,
  input wire logic [15:0] partner_in,
  input wire logic [31:0] an_at_in,
  output logic phy_d_out,
  output logic phy_oe_out,
  output int n_frames_out,
  output int n_stat_out,
  output logic [13:0] hdr_out,
  output int pre_cnt_out,
  output int err_out
);
  int pos;
  int ones;
  logic [13:0] hdr_q;
  logic [15:0] rd_q;
  realtime t_rise, t_fall, t_chg;

  initial begin
    pos = -1;
    ones = 0;
    hdr_q = '0;
    rd_q = '0;
    t_rise = 0;
    t_fall = 0;
    t_chg = 0;
    phy_d_out = 1'b1;
    phy_oe_out = 1'b0;
    n_frames_out = 0;
    n_stat_out = 0;
    hdr_out = '0;
    pre_cnt_out = 0;
    err_out = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mdc_in) begin
    if (t_rise > 0 && ($realtime - t_rise < 400.0 || $realtime - t_fall < 160.0)) err_out++;
    if ($realtime - t_chg < 10.0) err_out++;
    t_rise = $realtime;
    if (pos < 0) begin
      if (mdio_in) begin
        ones++;
      end else if (ones >= 32) begin
        pre_cnt_out = ones;
        hdr_q = '0;
        pos = 33;
      end else begin
        ones = 0;
      end
    end else begin
      if (pos <= 45) hdr_q = {hdr_q[12:0], mdio_in};
      // The master must have let go of the line from the turnaround to idle.
      if (pos >= 46 && mst_oe_in) err_out++;
      if (pos == 45 && hdr_q[4:0] == 5'h01) begin
        rd_q = (n_stat_out >= int'(an_at_in)) ? 16'h7829 : 16'h7809;
        n_stat_out++;
      end else if (pos == 45) begin
        rd_q = partner_in;
      end
      if (pos == 64) begin
        hdr_out = hdr_q;
        n_frames_out++;
        ones = 0;
      end
      pos = (pos == 64) ? -1 : pos + 1;
    end
  end

  always @(negedge mdc_in) begin
    if (t_rise > 0 && $realtime - t_rise < 160.0) err_out++;
    t_fall = $realtime;
    if (pos == 47) begin
      phy_oe_out <= #20 1'b1;
      phy_d_out <= #20 1'b0;
    end else if (pos >= 48 && pos <= 63) begin
      phy_d_out <= #20 rd_q[63 - pos];
    end else if (pos == 64) begin
      phy_oe_out <= #20 1'b0;
    end
  end

  // A change early in the high phase breaks the hold window of the sampler.
  always @(mdio_in) begin
    if (mdc_in === 1'b1 && $realtime - t_rise < 150.0) err_out++;
    t_chg = $realtime;
  end
endmodule : mamr_phy_model

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
  localparam logic [4:0] PHY_A = 5'h0b;
  // Short timeout keeps the failing-link case to a couple of frames.
  localparam longint TMO = 8000;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic start_in = 1'b0;
  logic pin_mode_in = 1'b0;
  logic pin_mdc_in = 1'b0;
  logic pin_mdio_in = 1'b0;
  logic pin_mdio_oe_in = 1'b0;
  logic mdc, mdio_o, mdio_oe, lvl, busy, done, dup, phy_d, phy_oe;
  logic [2:0] mode;
  logic [13:0] hdr;
  logic [15:0] partner = 16'h0000;
  logic [31:0] an_at = 32'h0000_0000;
  int n_frames, n_stat, pre_cnt, perr;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  // The line has a pull-up, so a released line reads high.
  wire logic mdio_line = mdio_oe ? mdio_o : (phy_oe ? phy_d : 1'b1);

  always #2 clk_in = ~clk_in;

  mamr_top #(.PHY_ADDR(PHY_A), .TIMEOUT_CYC(TMO)) u_mamr_top (.clk_in(clk_in), .resetn_in(resetn_in),
    .start_in(start_in), .pin_mode_in(pin_mode_in), .pin_mdc_in(pin_mdc_in), .pin_mdio_in(pin_mdio_in),
    .pin_mdio_oe_in(pin_mdio_oe_in), .mdio_in(mdio_line), .mdc_out(mdc), .mdio_out(mdio_o),
    .mdio_oe_out(mdio_oe), .pin_mdio_level_out(lvl), .busy_out(busy), .done_out(done),
    .link_mode_out(mode), .duplex_select_bit_out(dup));

  mamr_phy_model u_mamr_phy_model (.mdc_in(mdc), .mdio_in(mdio_line), .mst_oe_in(mdio_oe),
    .partner_in(partner), .an_at_in(an_at), .phy_d_out(phy_d), .phy_oe_out(phy_oe),
    .n_frames_out(n_frames), .n_stat_out(n_stat), .hdr_out(hdr), .pre_cnt_out(pre_cnt), .err_out(perr));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk_in) begin
    cyc++;
    // The scenarios need about 85000 cycles; the ceiling leaves a small margin.
    if (cyc == 95000) begin
      failures++;
      $display("[ERR] run length expected finish seen hang");
      complete_run();
    end
  end

  // Runs one readout; k status reads go by before negotiation reports done.
  task automatic judge(input int k, input logic [15:0] part, input bit again, input logic [2:0] md,
                       input logic dp, input int nf, input logic [4:0] rg);
    int f0;
    int i;
    f0 = n_frames;
    @(negedge clk_in);
    an_at = 32'(n_stat + k);
    partner = part;
    start_in = 1'b1;
    @(negedge clk_in);
    start_in = 1'b0;
    repeat (3) @(negedge clk_in);
    check("busy", {15'h0, busy}, 16'h0001);
    for (i = 0; i < 40000 && done !== 1'b1; i++) begin
      @(negedge clk_in);
      start_in = again && (i == 5000);
    end
    check("done", {15'h0, done}, 16'h0001);
    check("link mode", {13'h0, mode}, {13'h0, md});
    check("duplex", {15'h0, dup}, {15'h0, dp});
    if (nf > 0) check("frames", 16'(n_frames - f0), 16'(nf));
    check("header", {2'h0, hdr}, {2'h0, 2'h1, 2'h2, PHY_A, rg});
    check("preamble", 16'(pre_cnt), 16'h0020);
    check("wire faults", 16'(perr), 16'h0000);
  endtask : judge

  task automatic t_reset;
    repeat (8) @(negedge clk_in);
    check("reset outs", {7'h0, mdc, mdio_o, mdio_oe, busy, done, dup, mode}, 16'h0080);
    resetn_in = 1'b1;
  endtask : t_reset

  task automatic t_modes;
    judge(0, 16'h01e1, 1'b0, 3'h1, 1'b1, 2, 5'h05);
    judge(1, 16'h00c1, 1'b1, 3'h2, 1'b0, 3, 5'h05);
    judge(0, 16'h0021, 1'b0, 3'h4, 1'b0, 2, 5'h05);
    judge(0, 16'h0041, 1'b0, 3'h3, 1'b1, 2, 5'h05);
    judge(0, 16'h0001, 1'b0, 3'h7, 1'b1, 2, 5'h05);
  endtask : t_modes

  task automatic t_timeout;
    // Full duplex stands from the previous run, so a failed link must leave it set.
    judge(1000, 16'h01e1, 1'b0, 3'h7, 1'b1, 2, 5'h01);
  endtask : t_timeout

  task automatic t_override;
    @(negedge clk_in);
    pin_mode_in = 1'b1;
    pin_mdio_oe_in = 1'b1;
    repeat (10) @(negedge clk_in);
    check("pin drive", {13'h0, mdc, mdio_o, mdio_oe}, 16'h0001);
    check("pin level low", {15'h0, lvl}, 16'h0000);
    pin_mdc_in = 1'b1;
    repeat (50) @(negedge clk_in);
    check("pin clock", {15'h0, mdc}, 16'h0001);
    pin_mdc_in = 1'b0;
    pin_mdio_in = 1'b1;
    repeat (50) @(negedge clk_in);
    check("pin high", {14'h0, mdio_o, lvl}, 16'h0003);
    pin_mdio_oe_in = 1'b0;
    repeat (10) @(negedge clk_in);
    check("pin release", {14'h0, mdio_oe, lvl}, 16'h0001);
    pin_mode_in = 1'b0;
  endtask : t_override

  initial begin
    t_reset();
    t_modes();
    t_timeout();
    t_override();
    complete_run();
  end
endmodule : tb
